/* logic/ppm_pkg.sv */
// Package for the port pin function multiplexer
//
// Notes on behaviour
// - Low reset pin holds whole block reset
// - Master clock pin drives low only
// - Slave clock pin is input only
// - Data pin reads always, drives low only
// - Master and slave share one pin pair
// - port2_pin4 selectable as timer two trigger
// - port2_pin5 selectable as timer two count
// - port1_pin6 expanded irq or timer one count
// - port1_pin7 expanded irq, timer zero, clock
// - Programming serial clock enters on port1_pin7
// - Serial one receive pin3_6, transmit pin2_2
// - port0_pin7 serial receive, drive line, GPIO
// - Pins selectable as left or right drive lines
// - Power-down mode performs no scanning
// - Low-speed mode: slow scan, 32 kHz oscillator
// - Standard mode: fast scan only with finger present (else 32 kHz), 2 to 24 MHz
// - Two external interrupt pins; irq bits 2..7 held low
// - port0_pin6 selectable as serial zero transmit
package ppm_pkg;

    // Pin indices within the managed pin vector
    localparam int PIN_COUNT   = 16;
    localparam int P_LEFT1     = 0;   // left drive lines 1..11 on 0..10
    localparam int P_P2_0      = 3;
    localparam int P_P2_5      = 8;
    localparam int P_P2_4      = 9;
    localparam int P_P1_6      = 2;
    localparam int P_P3_6      = 11;
    localparam int P_P2_2      = 12;
    localparam int P_SCL       = 13;
    localparam int P_SDA       = 14;
    localparam int P_P1_7      = 15;
    localparam int P_P1_0      = 10;  // left drive line eleven (shared idx)
    localparam int LEFT_LINES  = 11;
    localparam int RIGHT_PINS  = 2;   // port0_pin7, port0_pin6
    localparam int IRQ_LINES   = 8;

    localparam logic [7:0] XOSC_OFF = 8'h00;

    // Function select per pin
    typedef enum logic [2:0] {
        FN_GPIO,
        FN_DRIVE,
        FN_ALT_A,
        FN_ALT_B,
        FN_ALT_C
    } ppm_func_type;

    typedef enum logic [1:0] {
        MODE_POWER_DOWN,
        MODE_LOW_SPEED,
        MODE_STANDARD
    } ppm_mode_type;

    typedef enum logic [1:0] {
        TW_NONE,
        TW_MASTER,
        TW_SLAVE
    } ppm_tw_type;

    // Two-wire controller side signals
    typedef struct packed {
        logic scl_out;
        logic sda_out;
    } ppm_tw_drive_type;

    // Peripheral inputs leaving the mux
    typedef struct packed {
        logic timer_two_trigger_in;
        logic timer_two_count_in;
        logic timer_one_count_in;
        logic timer_zero_count_in;
        logic ext_clock_in;
        logic serial_zero_receive;
        logic serial_one_receive;
        logic scl_in;
        logic sda_in;
    } ppm_periph_in_type;

    // Right-side pin functions (index 0: port0_pin7, 1: port0_pin6)
    typedef struct packed {
        logic [RIGHT_PINS-1:0] dout;
        logic [RIGHT_PINS-1:0] oe;
    } ppm_right_pins_type;

endpackage

/* logic/ppm_port_pin_function_mux.sv */
// Port pin function multiplexer, registered outputs, plain-port control
`timescale 1ns/1ps
module ppm_port_pin_function_mux
(
    input  wire logic                           clk_sys,
    input  wire logic                           srst,
    input  wire logic                           chip_reset_low,
    input  wire logic [7:0]                     crystal_osc_config,
    input  wire ppm_pkg::ppm_func_type [15:0]   pin_func,
    input  wire ppm_pkg::ppm_func_type [1:0]    right_func,
    input  wire ppm_pkg::ppm_tw_type            tw_select,
    input  wire ppm_pkg::ppm_mode_type          op_mode,
    input  wire logic                           finger_present,
    input  wire logic                           in_app_programming,
    input  wire logic [15:0]                    gpio_out,
    input  wire logic [15:0]                    gpio_oe,
    input  wire logic [1:0]                     right_gpio_out,
    input  wire logic [1:0]                     right_gpio_oe,
    input  wire logic [10:0]                    left_drive,
    input  wire logic [1:0]                     right_drive,
    input  wire logic                           serial_zero_transmit,
    input  wire logic                           serial_one_transmit,
    input  wire ppm_pkg::ppm_tw_drive_type      tw_master,
    input  wire ppm_pkg::ppm_tw_drive_type      tw_slave,
    input  wire logic [15:0]                    pin_in,
    input  wire logic [1:0]                     right_pin_in,
    output logic [15:0]                         pin_out,
    output logic [15:0]                         pin_oe,
    output ppm_pkg::ppm_right_pins_type         right_pins,
    output logic [15:0]                         gpio_in,
    output logic [1:0]                          right_gpio_in,
    output ppm_pkg::ppm_periph_in_type          periph_in,
    output logic [7:0]                          external_irq_pins,
    output logic                                scan_enable,
    output logic                                scan_fast,
    output logic                                osc_low_speed,
    output logic                                reset_active
);
    import ppm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic [1:0]  rpin_s1_q;
    logic [1:0]  rpin_s2_q;
    logic [1:0]  rst_s_q;
    logic        blk_rst;

    // block reset
    // Pin reset held low keeps outputs cleared, periph_in set to ones, reset_active high
    assign blk_rst = srst | ~rst_s_q[1];

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rst_s_q <= 2'h0;
        else
            rst_s_q <= {rst_s_q[0], chip_reset_low};
    end

    always_ff @(posedge clk_sys)
    begin
        if (blk_rst)
        begin
            pin_s1_q  <= 16'h0;
            pin_s2_q  <= 16'h0;
            rpin_s1_q <= 2'h0;
            rpin_s2_q <= 2'h0;
        end
        else
        begin
            pin_s1_q  <= pin_in;
            pin_s2_q  <= pin_s1_q;
            rpin_s1_q <= right_pin_in;
            rpin_s2_q <= rpin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-pin output selection
    logic        xosc_off;
    logic [15:0] out_d;
    logic [15:0] oe_d;
    logic        tw_master_sel;
    logic        tw_slave_sel;
    logic        tw_scl_drv;
    logic        tw_sda_drv;

    assign xosc_off = (crystal_osc_config == XOSC_OFF);

    assign tw_master_sel = (tw_select == TW_MASTER);
    assign tw_slave_sel  = (tw_select == TW_SLAVE);
    assign tw_sda_drv    = tw_master_sel ? tw_master.sda_out
                                         : tw_slave.sda_out;
    assign tw_scl_drv    = tw_master.scl_out;

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++)
        begin : g_pin
            logic osc_ok;
            logic is_drive;
            logic is_gpio;
            logic alt_out;
            logic alt_oe;
            logic drv_val;
            assign osc_ok = ((g != P_P2_0) && (g != P_P2_2)) || xosc_off;
            assign is_drive = (pin_func[g] == FN_DRIVE) && (g < LEFT_LINES);
            assign is_gpio  = (pin_func[g] == FN_GPIO) && osc_ok;
            // Only the left pins carry a drive line
            if (g < LEFT_LINES)
            begin : g_drv
                assign drv_val = left_drive[g];
            end
            else
            begin : g_nodrv
                assign drv_val = 1'b0;
            end
            if (g == P_P2_2)
            begin : g_tx1
                assign alt_out = serial_one_transmit;
                assign alt_oe  = (pin_func[g] == FN_ALT_A);
            end
            else if (g == P_SCL)
            begin : g_scl
                assign alt_out = 1'b0;
                assign alt_oe  = (pin_func[g] == FN_ALT_A) &&
                                 tw_master_sel && !tw_scl_drv;
            end
            else if (g == P_SDA)
            begin : g_sda
                assign alt_out = 1'b0;
                assign alt_oe  = (pin_func[g] == FN_ALT_A) &&
                                 (tw_master_sel || tw_slave_sel) &&
                                 !tw_sda_drv;
            end
            else
            begin : g_plain
                assign alt_out = 1'b0;
                assign alt_oe  = 1'b0;
            end
            assign out_d[g] = is_drive ? drv_val
                            : is_gpio  ? gpio_out[g] : alt_out;
            assign oe_d[g]  = is_drive | (is_gpio & gpio_oe[g]) | alt_oe;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Right-side pins: port0_pin7 (0) and port0_pin6 (1)
    ppm_right_pins_type right_d;
    logic [1:0]         r_drive;
    logic [1:0]         r_gpio;

    assign r_drive = {right_func[1] == FN_DRIVE, right_func[0] == FN_DRIVE};
    assign r_gpio  = {right_func[1] == FN_GPIO, right_func[0] == FN_GPIO};
    assign right_d.dout[1] = r_drive[1] ? right_drive[1]
                           : r_gpio[1]  ? right_gpio_out[1]
                           : serial_zero_transmit;
    assign right_d.oe[1]   = r_drive[1] | (r_gpio[1] & right_gpio_oe[1])
                           | (right_func[1] == FN_ALT_A);
    assign right_d.dout[0] = r_drive[0] ? right_drive[0] : right_gpio_out[0];
    assign right_d.oe[0]   = r_drive[0] | (r_gpio[0] & right_gpio_oe[0]);

    ////////////////////////////////////////////////////////////////////
    // Peripheral input routing
    ppm_periph_in_type periph_d;
    logic [7:0]        irq_d;
    logic              p17_a;

    assign periph_d.timer_two_trigger_in =
        (pin_func[P_P2_4] == FN_ALT_A) & pin_s2_q[P_P2_4];
    assign periph_d.timer_two_count_in =
        (pin_func[P_P2_5] == FN_ALT_A) & pin_s2_q[P_P2_5];
    assign periph_d.timer_one_count_in =
        (pin_func[P_P1_6] == FN_ALT_B) & pin_s2_q[P_P1_6];
    assign periph_d.timer_zero_count_in =
        (pin_func[P_P1_7] == FN_ALT_B) & pin_s2_q[P_P1_7];
    assign p17_a = (pin_func[P_P1_7] == FN_ALT_C) | in_app_programming;
    assign periph_d.ext_clock_in = p17_a & pin_s2_q[P_P1_7];
    assign periph_d.serial_zero_receive =
        (right_func[0] == FN_ALT_A) ? rpin_s2_q[0] : 1'b1;
    assign periph_d.serial_one_receive =
        (pin_func[P_P3_6] == FN_ALT_A) ? pin_s2_q[P_P3_6] : 1'b1;
    assign periph_d.scl_in =
        (pin_func[P_SCL] == FN_ALT_A) ? pin_s2_q[P_SCL] : 1'b1;
    assign periph_d.sda_in =
        (pin_func[P_SDA] == FN_ALT_A) ? pin_s2_q[P_SDA] : 1'b1;

    assign irq_d[0] = (pin_func[P_P1_6] == FN_ALT_A) & pin_s2_q[P_P1_6];
    assign irq_d[1] = (pin_func[P_P1_7] == FN_ALT_A) & pin_s2_q[P_P1_7];
    assign irq_d[IRQ_LINES-1:2] = 6'h00;

    ////////////////////////////////////////////////////////////////////
    // Operating mode
    logic scan_en_d;
    logic fast_d;

    assign scan_en_d = (op_mode != MODE_POWER_DOWN);
    assign fast_d = (op_mode == MODE_STANDARD) & finger_present;

    ////////////////////////////////////////////////////////////////////
    // Pin drive registers
    always_ff @(posedge clk_sys)
    begin
        if (blk_rst)
        begin
            pin_out <= 16'h0;
            pin_oe  <= 16'h0;
        end
        else
        begin
            pin_out <= out_d;
            pin_oe  <= oe_d;
        end
    end

    // Right-side pin registers
    always_ff @(posedge clk_sys)
    begin
        if (blk_rst)
            right_pins <= '0;
        else
            right_pins <= right_d;
    end

    // Sampled pin level registers
    always_ff @(posedge clk_sys)
    begin
        if (blk_rst)
        begin
            gpio_in       <= 16'h0;
            right_gpio_in <= 2'h0;
        end
        else
        begin
            gpio_in       <= pin_s2_q;
            right_gpio_in <= rpin_s2_q;
        end
    end

    // Peripheral and interrupt registers
    always_ff @(posedge clk_sys)
    begin
        if (blk_rst)
        begin
            periph_in         <= '1;
            external_irq_pins <= 8'h00;
        end
        else
        begin
            periph_in         <= periph_d;
            external_irq_pins <= irq_d;
        end
    end

    // Scan mode registers
    always_ff @(posedge clk_sys)
    begin
        if (blk_rst)
        begin
            scan_enable   <= 1'b0;
            scan_fast     <= 1'b0;
            osc_low_speed <= 1'b0;
        end
        else
        begin
            scan_enable   <= scan_en_d;
            scan_fast     <= scan_en_d & fast_d;
            osc_low_speed <= scan_en_d & ~fast_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            reset_active <= 1'b1;
        else
            reset_active <= blk_rst;
    end

endmodule

/* test/ppm_mux_assertions.sv */
// Concurrent checks on the pin function mux ports
`timescale 1ns/1ps
module ppm_mux_checker
    import ppm_pkg::*;
(
    input wire logic                         clk_sys,
    input wire logic                         srst,
    input wire logic                         chip_reset_low,
    input wire logic [7:0]                   crystal_osc_config,
    input wire ppm_pkg::ppm_func_type [15:0] pin_func,
    input wire ppm_pkg::ppm_tw_type          tw_select,
    input wire ppm_pkg::ppm_mode_type        op_mode,
    input wire logic                         finger_present,
    input wire logic [10:0]                  left_drive,
    input wire ppm_pkg::ppm_tw_drive_type    tw_master,
    input wire logic [15:0]                  pin_out,
    input wire logic [15:0]                  pin_oe,
    input wire ppm_pkg::ppm_right_pins_type  right_pins,
    input wire logic [7:0]                   external_irq_pins,
    input wire logic                         scan_enable,
    input wire logic                         scan_fast,
    input wire logic                         osc_low_speed,
    input wire logic                         reset_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || !chip_reset_low);
    ////////////////////////////////////////////////////////////////////////
    sequence slave_held;
        tw_select == TW_SLAVE && pin_func[13] == FN_ALT_A
            ##1 tw_select == TW_SLAVE;
    endsequence
    sequence fast_req;
        !reset_active && op_mode == MODE_STANDARD && finger_present;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_reset_pin_holds: assert property (disable iff (srst)
        $fell(chip_reset_low) |-> ##[1:4] reset_active)
        else $error("reset pin did not reset block");
    chk_reset_outputs_quiet: assert property (
        reset_active |-> pin_oe == 16'h0000 && right_pins.oe == 2'h0
        && external_irq_pins == 8'h00) else $error("drive during reset");
    chk_master_scl_low: assert property (!reset_active
        && pin_func[13] == FN_ALT_A && tw_select == TW_MASTER
        && !tw_master.scl_out |=> pin_oe[13] && !pin_out[13])
        else $error("master clock not pulled low");
    chk_scl_open_drain: assert property (pin_func[13] == FN_ALT_A
        |=> !(pin_oe[13] && pin_out[13]))
        else $error("clock pin driven high");
    chk_slave_scl_input: assert property (slave_held |-> !pin_oe[13])
        else $error("slave clock pin driven");
    chk_sda_open_drain: assert property (pin_func[14] == FN_ALT_A
        |=> !(pin_oe[14] && pin_out[14]))
        else $error("data pin driven high");
    chk_osc_blocks_gpio: assert property (
        crystal_osc_config != XOSC_OFF && pin_func[3] == FN_GPIO
        && pin_func[12] == FN_GPIO |=> !pin_oe[3] && !pin_oe[12])
        else $error("gpio driven with oscillator on");
    chk_drive_line_out: assert property (
        !reset_active && pin_func[0] == FN_DRIVE
        |=> pin_oe[0] && pin_out[0] == $past(left_drive[0]))
        else $error("drive line not passed");
    chk_scan_power_down: assert property (
        op_mode == MODE_POWER_DOWN |=> !scan_enable && !scan_fast)
        else $error("scan in power down");
    chk_scan_fast_mode: assert property (
        fast_req |=> scan_enable && scan_fast && !osc_low_speed)
        else $error("standard mode not fast");
    chk_low_speed_osc: assert property (!reset_active
        && op_mode == MODE_LOW_SPEED |=> scan_enable && osc_low_speed
        && !scan_fast) else $error("low speed mode wrong");
    chk_irq_upper_zero: assert property (
        external_irq_pins[7:2] == 6'h00) else $error("irq high bits set");
endmodule
bind ppm_port_pin_function_mux ppm_mux_checker CHK (.clk_sys, .srst,
    .chip_reset_low, .crystal_osc_config, .pin_func, .tw_select, .op_mode,
    .finger_present, .left_drive, .tw_master, .pin_out, .pin_oe,
    .right_pins, .external_irq_pins, .scan_enable, .scan_fast,
    .osc_low_speed, .reset_active);

/* test/ppm_pin_partner.sv */
// External pin levels seen by the mux
`timescale 1ns/1ps
module ppm_pin_partner
    import ppm_pkg::*;
(
    input  wire logic [15:0]                pin_out,
    input  wire logic [15:0]                pin_oe,
    input  wire ppm_pkg::ppm_right_pins_type right_pins,
    input  wire logic [15:0]                ext,
    input  wire logic [1:0]                 right_ext,
    output logic [15:0]                     pin_in,
    output logic [1:0]                      right_pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    assign right_pin_in = (right_pins.oe & right_pins.dout)
        | (~right_pins.oe & right_ext);
endmodule

/* test/tb_port_pin_function_mux.sv */
// Testbench for the port pin function mux
`timescale 1ns/1ps
module tb_port_pin_function_mux;
    import ppm_pkg::*;
    logic clk_sys, srst, chip_reset_low, finger_present, in_app_programming;
    logic serial_zero_transmit, serial_one_transmit;
    logic scan_enable, scan_fast, osc_low_speed, reset_active;
    logic [7:0] crystal_osc_config, external_irq_pins;
    logic [15:0] gpio_out, gpio_oe, pin_in, pin_out, pin_oe, gpio_in, ext;
    logic [1:0] right_gpio_out, right_gpio_oe, right_drive, right_pin_in;
    logic [1:0] right_gpio_in, right_ext;
    logic [10:0] left_drive;
    ppm_func_type [15:0] pin_func;
    ppm_func_type [1:0] right_func;
    ppm_tw_type tw_select;
    ppm_mode_type op_mode;
    ppm_tw_drive_type tw_master, tw_slave;
    ppm_right_pins_type right_pins;
    ppm_periph_in_type periph_in;
    int err_count, tests_run;
    ppm_port_pin_function_mux DUT (.clk_sys, .srst, .chip_reset_low,
        .crystal_osc_config, .pin_func, .right_func, .tw_select, .op_mode,
        .finger_present, .in_app_programming, .gpio_out, .gpio_oe,
        .right_gpio_out, .right_gpio_oe, .left_drive, .right_drive,
        .serial_zero_transmit, .serial_one_transmit, .tw_master, .tw_slave,
        .pin_in, .right_pin_in, .pin_out, .pin_oe, .right_pins, .gpio_in,
        .right_gpio_in, .periph_in, .external_irq_pins, .scan_enable,
        .scan_fast, .osc_low_speed, .reset_active);
    ppm_pin_partner P (.pin_out, .pin_oe, .right_pins, .ext, .right_ext,
        .pin_in, .right_pin_in);
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_osc();
        gpio_oe = 16'h1008;
        gpio_out = 16'h1008;
        step(2);
        ck({pin_oe[12], pin_oe[3]}, 16'h0000);
        crystal_osc_config = XOSC_OFF;
        step(5);
        ck({pin_oe[12], pin_oe[3], pin_out[12], pin_out[3]}, 16'h000f);
        ck({gpio_in[12], gpio_in[3]}, 16'h0003);
        gpio_oe = 16'h0000;
        $display("test osc gpio done");
    endtask
    task automatic t_tw();
        pin_func[13] = FN_ALT_A;
        pin_func[14] = FN_ALT_A;
        tw_select = TW_MASTER;
        tw_master = '0;
        step(5);
        ck({pin_oe[14:13], pin_out[14:13], periph_in.scl_in},
            16'h0018);
        tw_master = '1;
        ext[14] = 1'b0;
        step(5);
        ck({pin_oe[14:13], periph_in.sda_in, periph_in.scl_in},
            16'h0001);
        tw_select = TW_SLAVE;
        tw_slave = '0;
        step(2);
        ck({pin_oe[14:13], pin_out[14:13]}, 16'h0008);
        tw_select = TW_NONE;
        ext[14] = 1'b1;
        $display("test two wire done");
    endtask
    task automatic t_alt();
        pin_func[9] = FN_ALT_A;
        pin_func[8] = FN_ALT_A;
        pin_func[2] = FN_ALT_B;
        pin_func[15] = FN_ALT_B;
        step(5);
        ck({periph_in.timer_two_trigger_in, periph_in.timer_two_count_in,
            periph_in.timer_one_count_in, periph_in.timer_zero_count_in},
            16'h000f);
        pin_func[2] = FN_ALT_A;
        pin_func[15] = FN_ALT_A;
        step(5);
        ck({external_irq_pins, periph_in.timer_one_count_in}, 16'h0006);
        in_app_programming = 1'b1;
        ext[15] = 1'b0;
        step(5);
        ck(periph_in.ext_clock_in, 16'h0000);
        ext[15] = 1'b1;
        step(5);
        ck(periph_in.ext_clock_in, 16'h0001);
        $display("test alt inputs done");
    endtask
    task automatic t_serial();
        pin_func[12] = FN_ALT_A;
        pin_func[11] = FN_ALT_A;
        right_func[0] = FN_ALT_A;
        right_func[1] = FN_ALT_A;
        ext[11] = 1'b0;
        right_ext = 2'b10;
        step(5);
        ck({pin_oe[12], pin_out[12], right_pins.oe[1], right_pins.dout[1]},
            16'h000a);
        ck({periph_in.serial_one_receive, periph_in.serial_zero_receive},
            16'h0000);
        serial_one_transmit = 1'b1;
        serial_zero_transmit = 1'b1;
        step(2);
        ck({pin_out[12], right_pins.dout[1]}, 16'h0003);
        $display("test serial done");
    endtask
    task automatic t_drive();
        for (int i = 0; i < 11; i++)
            pin_func[i] = FN_DRIVE;
        right_func[0] = FN_DRIVE;
        right_func[1] = FN_DRIVE;
        left_drive = 11'h5a5;
        right_drive = 2'b01;
        step(2);
        ck({pin_oe[10:0]}, 16'h07ff);
        ck({pin_out[10:0]}, 16'h05a5);
        ck({right_pins.oe, right_pins.dout}, 16'h000d);
        step(3);
        ck(right_gpio_in, 16'h0001);
        $display("test drive lines done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 3; m++)
            for (int f = 0; f < 2; f++)
            begin
                op_mode = ppm_mode_type'(m);
                finger_present = f[0];
                step(2);
                ck({scan_enable, scan_fast, osc_low_speed}, {m != 0,
                    m == 2 && f == 1, m != 0 && !(m == 2 && f == 1)});
            end
        $display("test modes done");
    endtask
    task automatic t_chip();
        chip_reset_low = 1'b0;
        step(5);
        ck({reset_active, pin_oe[14:0]}, 16'h8000);
        chip_reset_low = 1'b1;
        step(6);
        ck({reset_active, pin_oe[14:0]}, 16'h17ff);
        $display("test reset pin done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        #20000;
        err_count++;
        close_out();
    end
    initial
    begin
        err_count = 0;
        tests_run = 0;
        {srst, chip_reset_low, in_app_programming} = 3'b110;
        {finger_present, serial_zero_transmit, serial_one_transmit} = 3'b0;
        crystal_osc_config = 8'h5a;
        for (int i = 0; i < 16; i++)
            pin_func[i] = FN_GPIO;
        right_func[0] = FN_GPIO;
        right_func[1] = FN_GPIO;
        tw_select = TW_NONE;
        op_mode = MODE_POWER_DOWN;
        {gpio_out, gpio_oe, ext} = {16'h0000, 16'hffff, 16'hffff};
        {right_gpio_out, right_gpio_oe, right_drive, right_ext} = 8'hff;
        {left_drive, tw_master, tw_slave} = {11'h000, 4'hf};
        @(posedge clk_sys);
        step(8);
        ck({reset_active, pin_oe[14:0]}, 16'h8000);
        ck({external_irq_pins, right_pins}, 16'h0000);
        srst = 1'b0;
        gpio_oe = 16'h0000;
        right_gpio_oe = 2'b00;
        step(2);
        t_osc();
        t_tw();
        t_alt();
        t_serial();
        t_drive();
        t_modes();
        t_chip();
        close_out();
    end
endmodule
